/* design/mrm_exec.sv */
// execution sequencer for multi-register, peripheral byte, quick moves
// assumes the core supplies ea, register reads and a one-cycle bus ack
// Function
// - direction bit 0 stores, 1 loads
// - size bit 0 word, 1 long
// - store modes: ind, predec, disp, index, abs
// - load modes: ind, postinc, disp, index, abs, pc
// - mask from extension word, bit0 first
// - normal mask: d0-d7 then a0-a7
// - predecrement mask reversed, a7 first
// - peripheral bytes at address steps of two
// - peripheral high byte first, low last
// - peripheral address is areg plus displacement
// - peripheral opmode selects size and direction
// - word uses two bytes, long four
// - peripheral word field layout fixed
// - quick immediate sign-extended into data register
// - multi-register word loads sign-extended to 32 bits, peripheral word loads keep the upper half
// - control modes step address up by length
// - predecrement starts below ea, leaves areg last
// - quick sets n z, clears v c, keeps x
`timescale 1ns/1ps
`default_nettype none
`include "mrm_defs.svh"
module mrm_exec
	import mrm_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// instruction stream
	input wire logic start_in,
	input wire logic [15:0] op_in,
	input wire logic [15:0] ext_in,
	input wire logic [31:0] ea_in,
	// register file read
	input wire logic [31:0] rf_rdata_in,
	output logic [3:0] rf_ridx_out,
	// memory bus
	output mrm_bus_s bus_out,
	input wire logic bus_ack_in,
	input wire logic [31:0] bus_rdata_in,
	// results
	output mrm_rf_s rf_out,
	output mrm_cc_s cc_out,
	output logic illegal_out,
	output logic busy_out,
	output logic done_out
);
	logic rst_s1_reg, rst_s2_reg;
	logic rst_n;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rst_n = rst_s2_reg;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic dec_multi, dec_periph, dec_quick, dec_illegal;
	mrm_decode u_dec (
		.op_in(op_in),
		.is_multi_out(dec_multi),
		.is_periph_out(dec_periph),
		.is_quick_out(dec_quick),
		.illegal_out(dec_illegal)
	);

	function automatic logic [31:0] sext16(input logic [15:0] w);
		sext16 = {{16{w[15]}}, w};
	endfunction : sext16

	// mask bit to register index; reversed for predecrement
	function automatic logic [3:0] map_idx(input logic [3:0] b,
		input logic rev);
		map_idx = rev ? ~b : b;
	endfunction : map_idx

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	mrm_state_e state_reg;
	logic [15:0] mask_reg;
	logic [3:0] bit_reg;
	logic load_reg, long_reg, predec_reg, postinc_reg;
	logic [31:0] addr_reg, shift_reg;
	logic [2:0] areg_reg, dreg_reg;
	logic [1:0] bcnt_reg;
	logic pend_reg;
	logic [31:0] step;
	logic [3:0] cur_idx;
	logic [31:0] bdata;
	assign step = long_reg ? `MRM_STEP_LONG : `MRM_STEP_WORD;
	assign cur_idx = map_idx(bit_reg, predec_reg);
	assign bdata = {shift_reg[23:0], bus_rdata_in[7:0]};

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= MRM_IDLE;
			mask_reg <= 16'h0000;
			bit_reg <= 4'h0;
			load_reg <= 1'b0;
			long_reg <= 1'b0;
			predec_reg <= 1'b0;
			postinc_reg <= 1'b0;
			addr_reg <= 32'h00000000;
			shift_reg <= 32'h00000000;
			areg_reg <= 3'h0;
			dreg_reg <= 3'h0;
			bcnt_reg <= 2'h0;
			pend_reg <= 1'b0;
			bus_out <= '0;
			rf_out <= '0;
			cc_out <= '0;
			illegal_out <= 1'b0;
			done_out <= 1'b0;
			busy_out <= 1'b0;
		end else begin
			rf_out.we <= 1'b0;
			cc_out.we <= 1'b0;
			illegal_out <= 1'b0;
			done_out <= 1'b0;
			case (state_reg)
			MRM_IDLE: begin
				areg_reg <= op_in[2:0];
				dreg_reg <= op_in[11:9];
				if (start_in && dec_illegal) begin
					illegal_out <= 1'b1;
				end else if (start_in && dec_quick) begin
					rf_out <= '{idx: {1'b0, op_in[11:9]},
						value: {{24{op_in[7]}}, op_in[7:0]},
						we: 1'b1};
					cc_out <= '{n: op_in[7], z: (op_in[7:0] == 8'h00),
						v: 1'b0, c: 1'b0, we: 1'b1};
					done_out <= 1'b1;
				end else if (start_in && dec_multi) begin
					load_reg <= op_in[10];
					long_reg <= op_in[6];
					predec_reg <= (op_in[5:3] == `MRM_EA_PREDEC);
					postinc_reg <= (op_in[5:3] == `MRM_EA_POSTINC);
					mask_reg <= ext_in;
					bit_reg <= 4'h0;
					addr_reg <= (op_in[5:3] == `MRM_EA_PREDEC) ?
						ea_in - (op_in[6] ? `MRM_STEP_LONG :
						`MRM_STEP_WORD) : ea_in;
					state_reg <= MRM_MULTI;
					busy_out <= 1'b1;
				end else if (start_in && dec_periph) begin
					load_reg <= ~op_in[7];
					long_reg <= op_in[6];
					addr_reg <= ea_in + sext16(ext_in);
					bcnt_reg <= op_in[6] ? 2'h3 : 2'h1;
					state_reg <= MRM_PERIPH;
					busy_out <= 1'b1;
				end
			end
			MRM_MULTI: begin
				if (!pend_reg) begin
					if (!mask_reg[bit_reg]) begin
						if (bit_reg == 4'hf)
							state_reg <= MRM_DONE;
						bit_reg <= bit_reg + 4'h1;
					end else if (rf_ridx_out == cur_idx) begin
						// read index is registered: wait until it names
						// the register this bit selects
						bus_out <= '{addr: addr_reg, wdata: rf_rdata_in,
							write: ~load_reg, size: long_reg ? 2'h2 : 2'h1,
							req: 1'b1};
						pend_reg <= 1'b1;
					end
				end else if (bus_ack_in) begin
					bus_out.req <= 1'b0;
					pend_reg <= 1'b0;
					if (load_reg) begin
						rf_out <= '{idx: cur_idx,
							value: long_reg ? bus_rdata_in :
							sext16(bus_rdata_in[15:0]), we: 1'b1};
					end
					addr_reg <= predec_reg ? addr_reg - step :
						addr_reg + step;
					if (bit_reg == 4'hf)
						state_reg <= MRM_DONE;
					bit_reg <= bit_reg + 4'h1;
				end
			end
			MRM_PERIPH: begin
				if (!pend_reg) begin
					bus_out <= '{addr: addr_reg,
						wdata: {24'h000000, bcnt_reg == 2'h3 ?
						rf_rdata_in[31:24] : bcnt_reg == 2'h2 ?
						rf_rdata_in[23:16] : bcnt_reg == 2'h1 ?
						rf_rdata_in[15:8] : rf_rdata_in[7:0]},
						write: ~load_reg, size: 2'h0, req: 1'b1};
					pend_reg <= 1'b1;
				end else if (bus_ack_in) begin
					bus_out.req <= 1'b0;
					pend_reg <= 1'b0;
					shift_reg <= bdata;
					addr_reg <= addr_reg + `MRM_STEP_BYTE;
					bcnt_reg <= bcnt_reg - 2'h1;
					if (bcnt_reg == 2'h0) begin
						if (load_reg) begin
							rf_out <= '{idx: {1'b0, dreg_reg},
								value: long_reg ? bdata :
								{rf_rdata_in[31:16], bdata[15:0]}, we: 1'b1};
						end
						state_reg <= MRM_DONE;
					end
				end
			end
			MRM_DONE: begin
				// predecrement leaves areg at last stored operand
				if (predec_reg) begin
					rf_out <= '{idx: {1'b1, areg_reg},
						value: addr_reg + step, we: 1'b1};
				end else if (postinc_reg) begin
					rf_out <= '{idx: {1'b1, areg_reg}, value: addr_reg,
						we: 1'b1};
				end
				predec_reg <= 1'b0;
				postinc_reg <= 1'b0;
				busy_out <= 1'b0;
				done_out <= 1'b1; // flags untouched
				state_reg <= MRM_IDLE;
			end
			default: state_reg <= MRM_IDLE;
			endcase
		end
	end

	// register read select; peripheral uses the data register
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			rf_ridx_out <= 4'h0;
		else if (state_reg == MRM_PERIPH)
			rf_ridx_out <= {1'b0, dreg_reg};
		// idle shows the data register so a store can begin at once
		else if (state_reg == MRM_IDLE)
			rf_ridx_out <= {1'b0, op_in[11:9]};
		else
			rf_ridx_out <= map_idx(bit_reg, predec_reg);
	end
endmodule : mrm_exec
`default_nettype wire

/* design/mrm_defs.svh */
// constants for the data-movement execution unit
// assumes inclusion by bare name from the exec and decode modules
`ifndef MRM_DEFS_SVH
`define MRM_DEFS_SVH
`define MRM_EA_IND 3'h2
`define MRM_EA_POSTINC 3'h3
`define MRM_EA_PREDEC 3'h4
`define MRM_EA_DISP 3'h5
`define MRM_EA_INDEX 3'h6
`define MRM_EA_OTHER 3'h7
`define MRM_REG_ABSW 3'h0
`define MRM_REG_ABSL 3'h1
`define MRM_REG_PCD 3'h2
`define MRM_REG_PCX 3'h3
`define MRM_MULTI_TOP 5'h09
`define MRM_MULTI_MID 3'h1
`define MRM_PERIPH_TOP 4'h0
`define MRM_PERIPH_FIX 3'h1
`define MRM_QUICK_TOP 4'h7
`define MRM_OPM_WLOAD 3'h4
`define MRM_OPM_LLOAD 3'h5
`define MRM_OPM_WSTORE 3'h6
`define MRM_OPM_LSTORE 3'h7
`define MRM_STEP_WORD 32'h00000002
`define MRM_STEP_LONG 32'h00000004
`define MRM_STEP_BYTE 32'h00000002
`endif

/* design/mrm_pkg.sv */
// types shared by the data-movement execution unit
// assumes mrm_defs.svh on the include path
package mrm_pkg;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic write;
		logic [1:0] size; // 0 byte, 1 word, 2 long
		logic req;
	} mrm_bus_s;
	typedef struct packed {
		logic [3:0] idx; // 0..7 data, 8..15 address
		logic [31:0] value;
		logic we;
	} mrm_rf_s;
	typedef struct packed {
		logic n;
		logic z;
		logic v;
		logic c;
		logic we;
	} mrm_cc_s;
	typedef enum logic [3:0] {
		MRM_IDLE = 4'b0001,
		MRM_MULTI = 4'b0010,
		MRM_PERIPH = 4'b0100,
		MRM_DONE = 4'b1000
	} mrm_state_e;
endpackage : mrm_pkg

/* design/mrm_decode.sv */
// combinational decoder for the three data-movement operation words
// assumes op word comes from the same clock domain
`timescale 1ns/1ps
`default_nettype none
`include "mrm_defs.svh"
module mrm_decode
	import mrm_pkg::*;
(
	// operation word
	input wire logic [15:0] op_in,
	// decode results
	output logic is_multi_out,
	output logic is_periph_out,
	output logic is_quick_out,
	output logic illegal_out
);
	logic ea_ok;
	always_comb begin
		ea_ok = 1'b0;
		case (op_in[5:3])
			`MRM_EA_IND, `MRM_EA_DISP, `MRM_EA_INDEX: ea_ok = 1'b1;
			`MRM_EA_PREDEC: ea_ok = ~op_in[10];
			`MRM_EA_POSTINC: ea_ok = op_in[10];
			`MRM_EA_OTHER: ea_ok = (op_in[2:0] == `MRM_REG_ABSW) ||
				(op_in[2:0] == `MRM_REG_ABSL) ||
				(op_in[10] && (op_in[2:0] == `MRM_REG_PCD ||
				op_in[2:0] == `MRM_REG_PCX));
			default: ea_ok = 1'b0;
		endcase
	end
	logic multi_pat;
	logic periph_pat;
	assign multi_pat = (op_in[15:11] == `MRM_MULTI_TOP) &&
		(op_in[9:7] == `MRM_MULTI_MID);
	assign periph_pat = (op_in[15:12] == `MRM_PERIPH_TOP) && op_in[8] &&
		(op_in[5:3] == `MRM_PERIPH_FIX);
	assign is_multi_out = multi_pat && ea_ok;
	assign is_periph_out = periph_pat;
	assign is_quick_out = (op_in[15:12] == `MRM_QUICK_TOP) && !op_in[8];
	assign illegal_out = multi_pat && !ea_ok;
endmodule : mrm_decode
`default_nettype wire

/* tb/mrm_exec_chk.sv */
// port assertions for mrm_exec
// assumes op, ext and ea stay put until the operation ends
`timescale 1ns/1ps
`default_nettype none
module mrm_exec_chk import mrm_pkg::*; (
	// watched ports
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic busy_out,
	input wire logic illegal_out,
	input wire logic [15:0] op_in,
	input wire logic [15:0] ext_in,
	input wire logic [31:0] ea_in,
	input wire mrm_bus_s bus_out,
	input wire mrm_rf_s rf_out,
	input wire mrm_cc_s cc_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	logic go, qk, mu, pe, bad;
	logic [2:0] md;
	assign go = start_in && !busy_out;
	assign md = op_in[5:3];
	assign qk = op_in[15:12] == 4'h7 && !op_in[8];
	assign mu = op_in[15:11] == 5'h09 && op_in[9:7] == 3'h1;
	assign pe = op_in[15:12] == 4'h0 && op_in[8] && md == 3'h1;
	assign bad = md < 3'h2 || (!op_in[10] && md == 3'h3)
		|| (op_in[10] && md == 3'h4)
		|| (md == 3'h7 && op_in[2:0] > (op_in[10] ? 3'h3 : 3'h1));
	property p_qval;
		go && qk |=> rf_out.we && rf_out.idx == {1'b0, op_in[11:9]}
			&& rf_out.value == {{24{op_in[7]}}, op_in[7:0]};
	endproperty
	a_qval: assert property (p_qval) else $error("quick value");
	property p_qcc;
		go && qk |=> cc_out.we && cc_out.n == op_in[7] && !cc_out.v
			&& !cc_out.c && cc_out.z == (op_in[7:0] == 8'h00);
	endproperty
	a_qcc: assert property (p_qcc) else $error("quick flags");
	property p_nocc;
		go && (mu || pe) |=> !cc_out.we [*8];
	endproperty
	a_nocc: assert property (p_nocc) else $error("flags touched");
	property p_ill;
		go && mu |=> illegal_out == bad;
	endproperty
	a_ill: assert property (p_ill)
		else $error("illegal mode");
	// a lone top mask bit takes seventeen cycles to reach the bus
	property p_dir;
		go && mu && !bad && ext_in != 16'h0000 |-> ##[1:24] bus_out.req
			&& bus_out.write == !op_in[10]
			&& bus_out.size == (op_in[6] ? 2'h2 : 2'h1);
	endproperty
	a_dir: assert property (p_dir) else $error("dir or size");
	property p_ctl;
		go && mu && !bad && md != 3'h4 && ext_in != 16'h0000
			|-> ##[1:24] $rose(bus_out.req) && bus_out.addr == ea_in;
	endproperty
	a_ctl: assert property (p_ctl) else $error("first address");
	property p_pre;
		go && mu && !bad && md == 3'h4 && ext_in != 16'h0000 |-> ##[1:24]
			$rose(bus_out.req)
			&& bus_out.addr == ea_in - (op_in[6] ? 32'h4 : 32'h2);
	endproperty
	a_pre: assert property (p_pre) else $error("predec address");
	property p_per;
		go && pe |-> ##[1:6] $rose(bus_out.req) && bus_out.size == 2'h0
			&& bus_out.addr == ea_in + {{16{ext_in[15]}}, ext_in};
	endproperty
	a_per: assert property (p_per) else $error("periph address");
endmodule : mrm_exec_chk
bind mrm_exec mrm_exec_chk chk (.clk_in(clk_in), .rstn_in(rstn_in),
	.start_in(start_in), .busy_out(busy_out), .illegal_out(illegal_out),
	.op_in(op_in), .ext_in(ext_in), .ea_in(ea_in), .bus_out(bus_out),
	.rf_out(rf_out), .cc_out(cc_out));
`default_nettype wire

/* tb/mrm_mem.sv */
// memory bus responder, prompt or two cycles slow
// assumes req is held until the cycle after ack
`timescale 1ns/1ps
`default_nettype none
module mrm_mem import mrm_pkg::*; (
	// bus side
	input wire logic clk_in,
	input wire mrm_bus_s bus_in,
	input wire logic slow_in,
	output logic ack_out,
	output logic [31:0] rdata_out
);
	logic [1:0] wait_reg = 2'h0;
	initial ack_out = 1'b0;
	initial rdata_out = 32'h0;
	always @(posedge clk_in) begin
		if (ack_out || !bus_in.req) begin
			ack_out <= 1'b0;
			wait_reg <= 2'h0;
		end else if (wait_reg >= {slow_in, 1'b0})
			ack_out <= 1'b1;
		else
			wait_reg <= wait_reg + 2'h1;
		// idle data toggles so a stale read never looks right
		rdata_out <= bus_in.req ? bus_in.addr * 32'h9e3779b1 : ~rdata_out;
	end
endmodule : mrm_mem
`default_nettype wire

/* tb/mrm_exec_tb.sv */
// self-checking bench for mrm_exec
// assumes mrm_mem on the bus and regv as the register file
`timescale 1ns/1ps
`default_nettype none
module mrm_exec_tb import mrm_pkg::*;;
	logic clk_in = 0, rstn_in = 0, start_in = 0, ack, slow = 1, done;
	logic ill, busy, bz;
	logic [15:0] op_in = 0, ext_in = 0;
	logic [31:0] ea_in = 0, rdata, lf = 32'h683cc044, r, ad, dv, ex;
	logic [3:0] ridx;
	mrm_bus_s bus;
	mrm_rf_s rf;
	mrm_cc_s cc, cv;
	logic [31:0] qa[$], qd[$], rv[$];
	logic [3:0] ri[$];
	logic qw[$];
	int num_errors = 0, total_checks = 0, k, n, ni;
	always #10 clk_in = ~clk_in;
	function automatic logic [31:0] regv(input logic [3:0] i);
		return 32'hc1a59e30 ^ {8{i}};
	endfunction : regv
	function automatic logic [31:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction : rnd
	mrm_exec dut (.clk_in(clk_in), .rstn_in(rstn_in), .start_in(start_in),
		.op_in(op_in), .ext_in(ext_in), .ea_in(ea_in), .rf_ridx_out(ridx),
		.rf_rdata_in(regv(ridx)), .bus_out(bus), .bus_ack_in(ack),
		.bus_rdata_in(rdata), .rf_out(rf), .cc_out(cc), .illegal_out(ill),
		.busy_out(busy), .done_out(done));
	mrm_mem mem (.clk_in(clk_in), .bus_in(bus), .slow_in(slow),
		.ack_out(ack), .rdata_out(rdata));
	always @(posedge clk_in) begin
		if (bus.req && ack) begin
			qa.push_back(bus.addr);
			qd.push_back(bus.wdata);
			qw.push_back(bus.write);
		end
		if (rf.we) begin
			ri.push_back(rf.idx);
			rv.push_back(rf.value);
		end
		if (cc.we)
			cv = cc;
		if (ill)
			ni++;
	end
	task automatic summarize();
		if (num_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s exp %h got %h", s, e, g);
		end
	endtask : chk
	// illegal ops end on the illegal pulse instead of done
	task automatic run(logic [15:0] op, logic [15:0] e, logic [31:0] a);
		int t;
		qa.delete();
		qd.delete();
		qw.delete();
		ri.delete();
		rv.delete();
		ni = 0;
		cv = '0;
		{op_in, ext_in, ea_in, start_in} = {op, e, a, 1'b1};
		@(posedge clk_in);
		#1 start_in = 1'b0;
		bz = busy;
		for (t = 0; t < 300 && !done && !ill; t++) @(posedge clk_in) #1;
		if (t == 300) begin
			num_errors++;
			$display("mismatch done exp 1 got 0");
			summarize();
		end
		repeat (3) @(posedge clk_in) #1;
	endtask : run
	initial begin
		logic [6:0] mt[13] = '{7'h13, 7'h25, 7'h38, 7'h34, 7'h39, 7'h5a,
			7'h69, 7'h7a, 7'h79, 7'h7b, 7'h5e, 7'h2c, 7'h6c};
		logic [6:0] bad[4] = '{7'h1a, 7'h60, 7'h00, 7'h7c};
		repeat (16) @(posedge clk_in);
		#1 rstn_in = 1'b1;
		repeat (4) @(posedge clk_in) #1;
		for (int i = 0; i < 6; i++) begin
			r = rnd();
			if (i < 2) r[7:0] = i ? 8'h80 : 8'h00;
			run({4'h7, r[11:9], 1'b0, r[7:0]}, r[31:16], r);
			chk("qval", {{24{r[7]}}, r[7:0]}, rv[0]);
			chk("qidx", r[11:9], ri[0]);
			chk("qcc", {r[7], r[7:0] == 8'h00, 3'h1}, cv);
		end
		foreach (bad[i]) begin
			run({5'h09, bad[i][6], 4'h3, bad[i][5:0]}, 16'hffff, 32'h400);
			chk("ibus", 0, qa.size());
			chk("ill", 1, ni);
		end
		for (int j = 0; j < 26; j++) begin
			r = rnd();
			slow = !mt[j % 13][6] | r[21];
			ea_in = {16'h0, r[31:24], 8'h40};
			// base register kept out of the mask in both mappings
			ext_in = r[15:0] & ~(16'h0100 << mt[j % 13][2:0])
				& ~(16'h0080 >> mt[j % 13][2:0]);
			n = r[20] ? 4 : 2;
			run({5'h09, mt[j % 13][6], 3'h1, r[20], mt[j % 13][5:0]},
				ext_in, ea_in);
			k = op_in[10] ? $countones(ext_in) : 0;
			if (op_in[5:3] == 3'h3 || op_in[5:3] == 3'h4) k++;
			chk("mwrites", k, ri.size());
			chk("mcount", $countones(ext_in), qa.size());
			chk("mbusy", 1, bz);
			chk("mcc", 0, cv.we);
			chk("mill", 0, ni);
			k = 0;
			for (int b = 0; b < 16; b++) if (ext_in[b]) begin
				ad = op_in[5:3] == 3'h4 ? ea_in - n * (k + 1) : ea_in + n * k;
				chk("maddr", ad, qa[k]);
				chk("mdir", !op_in[10], qw[k]);
				dv = op_in[10] ? ad * 32'h9e3779b1 : regv(op_in[5:3] == 3'h4
					? 4'(15 - b) : 4'(b));
				if (n == 2) dv = {{16{dv[15] & op_in[10]}}, dv[15:0]};
				if (!op_in[10]) begin
					ex = n == 4 ? qd[k] : {16'h0, qd[k][15:0]};
					chk("mdata", dv, ex);
				end else begin
					chk("midx", b, ri[k]);
					chk("mload", dv, rv[k]);
				end
				k++;
			end
			// address register left at the last operand, or one past it
			ad = op_in[5:3] == 3'h4 ? ea_in - n * k : ea_in + n * k;
			if (op_in[5:3] == 3'h4 || op_in[5:3] == 3'h3) begin
				chk("mwb", ad, rv[$]);
				chk("mwbidx", {1'b1, op_in[2:0]}, ri[$]);
			end
		end
		for (int o = 4; o < 8; o++) begin
			r = rnd();
			slow = 1'b1;
			n = o[0] ? 4 : 2;
			run({4'h0, r[2:0], o[2:0], 3'h1, r[5:3]},
				o == 4 ? 16'hfffe : r[31:16], {16'h0, r[15:0]});
			chk("pcount", n, qa.size());
			chk("pbusy", 1, bz);
			chk("pcc", 0, cv.we);
			ex = 0;
			for (k = 0; k < n; k++) begin
				ad = ea_in + {{16{ext_in[15]}}, ext_in} + 2 * k;
				chk("paddr", ad, qa[k]);
				chk("pdir", o[1], qw[k]);
				dv = regv({1'b0, r[2:0]}) >> (8 * (n - 1 - k));
				if (o[1]) chk("pbyte", dv[7:0], qd[k][7:0]);
				dv = ad * 32'h9e3779b1;
				ex = {ex[23:0], dv[7:0]};
			end
			if (!o[1]) begin
				dv = n == 4 ? rv[0] : {16'h0, rv[0][15:0]};
				chk("pload", ex, dv);
				chk("pidx", r[2:0], ri[0]);
			end
		end
		chk("busy", 0, busy);
		summarize();
	end
endmodule : mrm_exec_tb
`default_nettype wire
